// [lds_pkg.sv]
// package of constants for the led driver serial slave port
package lds_pkg;
  localparam logic [4:0] DEV_ADDR_HI = 5'h0A;
  localparam logic [7:0] SECTION_SEL_OFS = 8'hFD;
  localparam logic [7:0] SECTION_CTRL = 8'h0B;
  localparam logic [7:0] SECTION_RESET = 8'h00;
  localparam logic [7:0] SHUTDOWN_CTRL_OFS = 8'h0A;
  localparam logic [7:0] SHUTDOWN_CTRL_RESET = 8'h00;
  localparam int SHUTDOWN_RUN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_WORDS = 32;
  localparam int CTRL_AW = 5;
  localparam int SCL_MAX_KHZ = 1000;
  localparam int CLK_MHZ = 125;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ADDR_ACK = 6'b000100,
    ST_RX = 6'b001000,
    ST_TX = 6'b010000,
    ST_IGNORE = 6'b100000
  } lds_state_e;
endpackage

// [lds_ctrl_ram.sv]
// small register memory holding the control register bank
`timescale 1ns/10ps
module lds_ctrl_ram
  import lds_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [CTRL_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [CTRL_AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff
);
  logic [7:0] mem_ff [CTRL_WORDS];

  // defaults loaded on reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CTRL_WORDS; i++) begin
        mem_ff[i] <= CTRL_RESET;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data_ff <= CTRL_RESET;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule

// [lds_serial_slave.sv]
// two-wire serial slave port with register access and shutdown control
// Summary of operation
// - slave only, clock up to 1MHz
// - data stable while clock high
// - sda fall with scl high starts
// - sda rise with scl high stops
// - any number of bytes accepted
// - eight bits then ninth ack pulse
// - ack holds sda low whole high
// - release sda after master nack
// - ack address and every written byte
// - repeated start restarts address phase
// - address compared by hardware
// - lsb one reads, zero writes
// - address bits 1,2 from straps
// - ack matching address on ninth pulse
// - section select at 253, 11 control
// - reset loads defaults, enters shutdown
// - shutdown register halts display logic
// - shutdown pin forces full shutdown
`timescale 1ns/10ps
module lds_serial_slave
  import lds_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  input wire logic hw_shutdown_n,
  output logic display_run,
  output logic por_enable,
  output logic [7:0] section_sel
);
  logic [1:0] scl_sync_ff, sda_sync_ff, strap0_sync_ff, strap1_sync_ff, hwsd_sync_ff;
  logic scl_d_ff, sda_d_ff;
  lds_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] reg_ptr_ff;
  logic ptr_loaded_ff;
  logic read_ff;
  logic ack_drive_ff;
  logic tx_drive_ff;
  logic master_nack_ff;
  logic [7:0] section_ff;
  logic [7:0] shutdown_ff;
  logic [1:0] strap_ff;
  logic [7:0] ram_rd;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_done, ram_wr;
  logic ack_end, tx_load, addr_hit;
  logic [7:0] rx_byte, tx_byte;

  function automatic logic is_ctrl_addr(input logic [7:0] a);
    return a < 8'(CTRL_WORDS);
  endfunction

  // reads beyond the control bank return zero
  function automatic logic [7:0] tx_source(input logic [7:0] ptr, input logic [7:0] rd);
    return is_ctrl_addr(ptr) ? rd : 8'h00;
  endfunction

  // upper bits fixed, bits 2:1 from the straps
  function automatic logic addr_match(input logic [6:0] a, input logic [1:0] s);
    return a == {DEV_ADDR_HI, s};
  endfunction

  // two-flop synchronisers for the bus pins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
    end
  end

  // two-flop synchronisers for the static pins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strap0_sync_ff <= 2'h0;
      strap1_sync_ff <= 2'h0;
      hwsd_sync_ff <= 2'h3;
    end else begin
      strap0_sync_ff <= {strap0_sync_ff[0], addr_strap_low};
      strap1_sync_ff <= {strap1_sync_ff[0], addr_strap_high};
      hwsd_sync_ff <= {hwsd_sync_ff[0], hw_shutdown_n};
    end
  end

  // delayed bus levels for edge and condition detection
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strap_ff <= 2'h0;
    end else begin
      strap_ff <= {strap1_sync_ff[1], strap0_sync_ff[1]};
    end
  end

  assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
  assign start_det = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];
  assign byte_done = scl_rise && (bit_cnt_ff == BIT_LAST);
  // falling clock that ends the acknowledge slot
  assign ack_end = scl_fall && (bit_cnt_ff == BIT_ACK);
  // a byte is fetched for every transmit slot, the first one included
  assign tx_load = ack_end && (nxt_state == ST_TX);
  assign rx_byte = {shift_ff[6:0], sda_sync_ff[1]};
  assign tx_byte = tx_source(reg_ptr_ff, ram_rd);
  assign addr_hit = addr_match(shift_ff[6:0], strap_ff);

  // bit counter: 0..7 data, 8 acknowledge slot
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bit_cnt_ff <= 4'h0;
    end else if (start_det) begin
      // the falling clock that closes a start must not count as a bit
      bit_cnt_ff <= BIT_ACK;
    end else if (stop_det) begin
      bit_cnt_ff <= 4'h0;
    end else if (scl_fall) begin
      bit_cnt_ff <= (bit_cnt_ff == BIT_ACK) ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  // sample on rising clock, shift out on falling clock for reads
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift_ff <= 8'h00;
    end else if (scl_rise && bit_cnt_ff != BIT_ACK && state_ff != ST_TX) begin
      shift_ff <= rx_byte;
    end else if (tx_load) begin
      shift_ff <= tx_byte;
    end else if (state_ff == ST_TX && scl_fall && bit_cnt_ff != BIT_ACK) begin
      shift_ff <= {shift_ff[6:0], 1'b1};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_ADDR: begin
        if (byte_done) begin
          if (addr_hit) begin
            nxt_state = ST_ADDR_ACK;
          end else begin
            nxt_state = ST_IGNORE;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall && bit_cnt_ff == BIT_ACK) begin
          nxt_state = read_ff ? ST_TX : ST_RX;
        end
      end
      ST_RX: nxt_state = ST_RX;
      ST_TX: begin
        if (scl_fall && bit_cnt_ff == BIT_ACK && master_nack_ff) begin
          nxt_state = ST_IGNORE;
        end
      end
      ST_IGNORE: nxt_state = ST_IGNORE;
      default: nxt_state = ST_IDLE;
    endcase
    if (start_det) begin
      nxt_state = ST_ADDR;
    end else if (stop_det) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // direction bit caught with the address byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      read_ff <= 1'b0;
    end else if (state_ff == ST_ADDR && byte_done) begin
      read_ff <= sda_sync_ff[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      master_nack_ff <= 1'b0;
    end else if (state_ff == ST_TX && scl_rise && bit_cnt_ff == BIT_ACK) begin
      master_nack_ff <= sda_sync_ff[1];
    end
  end

  // first written byte is the register pointer, later bytes are data
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ptr_loaded_ff <= 1'b0;
      reg_ptr_ff <= 8'h00;
    end else if (start_det) begin
      ptr_loaded_ff <= 1'b0;
    end else if (state_ff == ST_RX && byte_done) begin
      if (!ptr_loaded_ff) begin
        ptr_loaded_ff <= 1'b1;
        reg_ptr_ff <= rx_byte;
      end else begin
        reg_ptr_ff <= reg_ptr_ff + 8'h01;
      end
    end else if (tx_load) begin
      // advance on each fetch so the next fetch reads the following word
      reg_ptr_ff <= reg_ptr_ff + 8'h01;
    end
  end

  assign ram_wr = state_ff == ST_RX && byte_done && ptr_loaded_ff && section_ff == SECTION_CTRL
                  && is_ctrl_addr(reg_ptr_ff);

  // section select holds until rewritten
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      section_ff <= SECTION_RESET;
    end else if (state_ff == ST_RX && byte_done && ptr_loaded_ff && reg_ptr_ff == SECTION_SEL_OFS) begin
      section_ff <= rx_byte;
    end
  end

  // shutdown register, cleared by reset so the device starts shut down
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shutdown_ff <= SHUTDOWN_CTRL_RESET;
    end else if (ram_wr && reg_ptr_ff == SHUTDOWN_CTRL_OFS) begin
      shutdown_ff <= rx_byte;
    end
  end

  // ack drive for address and received bytes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_drive_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_drive_ff <= 1'b0;
    end else if (scl_fall && bit_cnt_ff == BIT_LAST && (nxt_state == ST_ADDR_ACK || state_ff == ST_RX)) begin
      ack_drive_ff <= 1'b1;
    end else if (scl_fall && bit_cnt_ff == BIT_ACK) begin
      ack_drive_ff <= 1'b0;
    end
  end

  // transmit drive: low only for zero data bits, released on ack slot
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_drive_ff <= 1'b0;
    end else if (start_det || stop_det || nxt_state != ST_TX) begin
      tx_drive_ff <= 1'b0;
    end else if (tx_load) begin
      tx_drive_ff <= !tx_byte[7];
    end else if (scl_fall && bit_cnt_ff == BIT_LAST) begin
      tx_drive_ff <= 1'b0;
    end else if (scl_fall) begin
      tx_drive_ff <= !shift_ff[6];
    end
  end

  lds_ctrl_ram u_ram (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(ram_wr),
    .wr_addr(reg_ptr_ff[CTRL_AW-1:0]),
    .wr_data(rx_byte),
    .rd_addr(reg_ptr_ff[CTRL_AW-1:0]),
    .rd_data_ff(ram_rd)
  );

  // open drain: only ever pulls low, never drives the clock
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive_ff || tx_drive_ff;
  assign display_run = shutdown_ff[SHUTDOWN_RUN_BIT] && hwsd_sync_ff[1];
  assign por_enable = hwsd_sync_ff[1];
  assign section_sel = section_ff;
endmodule

// [lds_serial_slave_chk.sv]
// assertion checker for the serial slave port pins
`timescale 1ns/10ps
module lds_serial_slave_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic hw_shutdown_n,
  input wire logic display_run,
  input wire logic por_enable
);
  logic [7:0] oe_run_ff;
  always_ff @(posedge core_clk) begin
    if (!reset_n || !sda_oe) oe_run_ff <= 8'h00;
    else if (oe_run_ff != 8'hFF) oe_run_ff <= oe_run_ff + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_pin_held;
    !hw_shutdown_n [*4];
  endsequence
  a_open_drain_low: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  a_oe_rise_late: assert property ($rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("sda pulled too early");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in) else $error("sda freed in high");
  a_start_no_drive: assert property (s_start |=> !sda_oe [*8]) else $error("driven after start");
  a_oe_run_bound: assert property (oe_run_ff < 8'hA0) else $error("sda held too long");
  a_pin_stops_run: assert property (s_pin_held |-> !display_run) else $error("run in shutdown");
  a_pin_stops_por: assert property (s_pin_held |-> !por_enable) else $error("por kept on");
endmodule
bind lds_serial_slave lds_serial_slave_chk i_lds_serial_slave_chk (.core_clk(core_clk), .reset_n(reset_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .hw_shutdown_n(hw_shutdown_n),
  .display_run(display_run), .por_enable(por_enable));

// [lds_mstr.sv]
// two-wire bus master model, open drain data
`timescale 1ns/10ps
module lds_mstr (
  output logic scl,
  output logic sda_dn,
  input wire logic sda
);
  // quarter of the 125 ns bus clock period
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  task automatic start();
    // keeps every bus edge off the core clock edges
    #0.1;
    sda_dn = 1'b0;
    #Q scl = 1'b1;
    #Q sda_dn = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_dn = 1'b1;
    #Q scl = 1'b1;
    #Q sda_dn = 1'b0;
    #Q;
  endtask
  // data changes only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_dn = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // eight bits msb first, then ack slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// [led_driver_serial_slave_port_bench.sv]
// self-checking bench for the led driver serial slave port
`timescale 1ns/10ps
module led_driver_serial_slave_port_bench;
  import lds_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap_lo = 1'b1;
  logic strap_hi = 1'b0;
  logic hw_shutdown_n = 1'b1;
  wire scl, sda_dn, sda_out, sda_oe, display_run, por_enable;
  wire [7:0] section_sel;
  wire sda = !(sda_dn || sda_oe);
  int bad_count = 0;
  int num_checks = 0;
  initial forever #4 core_clk = !core_clk;
  lds_mstr i_lds_mstr (.scl(scl), .sda_dn(sda_dn), .sda(sda));
  lds_serial_slave i_lds_serial_slave (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(strap_lo), .addr_strap_high(strap_hi),
    .hw_shutdown_n(hw_shutdown_n), .display_run(display_run), .por_enable(por_enable),
    .section_sel(section_sel));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] adr(logic ok, logic rw);
    return {DEV_ADDR_HI, strap_hi ^ !ok, strap_lo, rw};
  endfunction
  task automatic put(logic [7:0] b, logic exp_ack);
    logic [7:0] rx;
    logic ack;
    i_lds_mstr.xfer(b, 1'b1, rx, ack);
    check("ack", {7'h00, exp_ack}, {7'h00, !ack});
  endtask
  task automatic get(logic nack, logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    i_lds_mstr.xfer(8'hFF, nack, rx, ack);
    check("read data", exp, rx);
  endtask
  task automatic wr(logic [7:0] ptr, logic [7:0] d);
    i_lds_mstr.start();
    put(adr(1, 0), 1);
    put(ptr, 1);
    put(d, 1);
    i_lds_mstr.stop();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_write();
    check("section_sel", SECTION_RESET, section_sel);
    check("display_run", 8'h00, {7'h00, display_run});
    wr(SECTION_SEL_OFS, SECTION_CTRL);
    check("section_sel", SECTION_CTRL, section_sel);
    wr(SHUTDOWN_CTRL_OFS, 8'h01);
    check("display_run", 8'h01, {7'h00, display_run});
    i_lds_mstr.start();
    put(adr(1, 0), 1);
    put(8'h01, 1);
    put(8'h22, 1);
    put(8'h33, 1);
    put(8'h44, 1);
    i_lds_mstr.stop();
  endtask
  task automatic t_read();
    i_lds_mstr.start();
    put(adr(1, 0), 1);
    put(8'h02, 1);
    i_lds_mstr.start();
    put(adr(1, 1), 1);
    get(0, 8'h33);
    get(1, 8'h44);
    i_lds_mstr.stop();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_foreign();
    i_lds_mstr.start();
    put(adr(0, 0), 0);
    put(SECTION_SEL_OFS, 0);
    put(8'h01, 0);
    i_lds_mstr.stop();
    repeat (8) @(posedge core_clk);
    check("section_sel", SECTION_CTRL, section_sel);
    @(posedge core_clk);
    strap_lo <= 1'b0;
    strap_hi <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(SHUTDOWN_CTRL_OFS, 8'h00);
    check("display_run", 8'h00, {7'h00, display_run});
  endtask
  task automatic t_pin();
    wr(SHUTDOWN_CTRL_OFS, 8'h01);
    hw_shutdown_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    check("display_run", 8'h00, {7'h00, display_run});
    check("por_enable", 8'h00, {7'h00, por_enable});
    hw_shutdown_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("display_run", 8'h01, {7'h00, display_run});
    check("por_enable", 8'h01, {7'h00, por_enable});
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_write();
    t_read();
    t_foreign();
    t_pin();
    tally_and_finish();
  end
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule
